// ---- inc/ccr_pkg.sv ----
package ccr_pkg;
	// SMBus slave address and command bytes
	localparam logic [6:0] SLAVE_ADDR = 7'h09;
	localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
	localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
	localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3F;
	// Input limit word layout
	localparam int INPUT_LIMIT_LSB = 7;
	localparam int INPUT_LIMIT_MSB = 12;
	localparam logic [15:0] INPUT_LIMIT_RESET = 16'h0000;
	localparam logic [15:0] CHARGE_VOLTAGE_RESET = 16'h0000;
	localparam logic [15:0] CHARGE_CURRENT_RESET = 16'h0000;
	// Watchdog timing
	localparam int CLK_HZ = 100_000_000;
	localparam int WATCHDOG_S = 175;
	localparam longint WATCHDOG_CYCLES = longint'(WATCHDOG_S) * longint'(CLK_HZ);
endpackage

// ---- src/ccr_charger_core.sv ----
module ccr_charger_core #(
	parameter longint WATCHDOG_CYCLES = ccr_pkg::WATCHDOG_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_bus_supply_ok,
	input wire logic i_input_supply_ok,
	input wire logic i_gate_drive_supply_ok,
	input wire logic i_reference_ok,
	input wire logic i_headroom_ok,
	input wire logic i_power_fail,
	input wire logic i_adapter_detect_input,
	output logic o_adapter_present_output_out,
	output logic o_adapter_present_output_oe,
	output logic o_charge_enable,
	output logic [15:0] o_input_limit,
	output logic [15:0] o_charge_voltage,
	output logic [15:0] o_charge_current
);
	// The watchdog counter is 40 bits wide and needs at least two counts
	if (WATCHDOG_CYCLES < 2 || WATCHDOG_CYCLES > 64'h0000_FFFF_FFFF) begin : g_bad_wdog
		$error("WATCHDOG_CYCLES out of range");
	end

	// Bus undervoltage acts as a reset for the register bank and the receiver
	logic rst_any_n;
	logic bus_ok_s1_r;
	logic bus_ok_s2_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_ok_s1_r <= 1'b0;
			bus_ok_s2_r <= 1'b0;
		end else begin
			bus_ok_s1_r <= i_bus_supply_ok;
			bus_ok_s2_r <= bus_ok_s1_r;
		end
	end
	assign rst_any_n = i_rst_n & i_bus_supply_ok;

	// Reset enters at once but leaves on a clock edge, so no bank flop sees it release mid-setup
	logic rst_s1_n_r;
	logic rst_s2_n_r;
	always_ff @(posedge i_clk or negedge rst_any_n) begin
		if (!rst_any_n) begin
			rst_s1_n_r <= 1'b0;
			rst_s2_n_r <= 1'b0;
		end else begin
			rst_s1_n_r <= 1'b1;
			rst_s2_n_r <= rst_s1_n_r;
		end
	end

	logic [7:0] rx_cmd;
	logic [15:0] rx_data;
	logic rx_tgl;
	ccr_smbus_rx u_rx (
		.i_scl(i_scl),
		.i_rst_n(rst_any_n),
		.i_sda_in(i_sda_in),
		.o_sda_out(o_sda_out),
		.o_sda_oe(o_sda_oe),
		.o_cmd(rx_cmd),
		.o_data(rx_data),
		.o_word_tgl(rx_tgl)
	);

	// Word toggle crosses by two flops; command is stable long before it flips, data changes on the same SCL edge and its one-flop copy settles first
	logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
	logic [7:0] cmd_hold_r;
	logic [15:0] data_hold_r;
	always_ff @(posedge i_clk or negedge rst_any_n) begin
		if (!rst_any_n) begin
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
			cmd_hold_r <= 8'h00;
			data_hold_r <= 16'h0000;
		end else begin
			tgl_s1_r <= rx_tgl;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
			cmd_hold_r <= rx_cmd;
			data_hold_r <= rx_data;
		end
	end
	logic word_evt;
	assign word_evt = tgl_s2_r ^ tgl_s3_r;

	// Analog flags come from outside this clock and pass two flops
	logic [6:0] flag_s1_r, flag_s2_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_s1_r <= 7'h00;
			flag_s2_r <= 7'h00;
		end else begin
			flag_s1_r <= {i_input_supply_ok, i_gate_drive_supply_ok, i_reference_ok, i_headroom_ok,
				i_power_fail, i_adapter_detect_input, 1'b0};
			flag_s2_r <= flag_s1_r;
		end
	end
	logic in_ok, gd_ok, ref_ok, head_ok, pfail, det;
	assign in_ok = flag_s2_r[6];
	assign gd_ok = flag_s2_r[5];
	assign ref_ok = flag_s2_r[4];
	assign head_ok = flag_s2_r[3];
	assign pfail = flag_s2_r[2];
	assign det = flag_s2_r[1];

	localparam logic [39:0] WD_LAST = 40'(WATCHDOG_CYCLES - 1);

	logic [15:0] ilim_r, ilim_nxt;
	logic [15:0] vset_r, vset_nxt;
	logic [15:0] iset_r, iset_nxt;
	logic got_v_r, got_v_nxt;
	logic got_i_r, got_i_nxt;
	logic [39:0] wd_r, wd_nxt;
	logic adapter_r, adapter_nxt;
	logic en_r, en_nxt;
	logic od_oe_r, od_oe_nxt;
	logic [15:0] ilim_eff;
	logic wd_expire;
	logic armed;

	always_comb begin
		ilim_nxt = ilim_r;
		vset_nxt = vset_r;
		iset_nxt = iset_r;
		got_v_nxt = got_v_r;
		got_i_nxt = got_i_r;
		armed = got_v_r & got_i_r;
		wd_expire = armed && (wd_r == WD_LAST);
		wd_nxt = armed ? wd_r + 40'h1 : 40'h0;
		if (word_evt) begin
			if (cmd_hold_r == ccr_pkg::CMD_INPUT_LIMIT) begin
				ilim_nxt = data_hold_r;
			end else if (cmd_hold_r == ccr_pkg::CMD_CHARGE_VOLTAGE) begin
				vset_nxt = data_hold_r;
				got_v_nxt = 1'b1;
				wd_nxt = 40'h0;
			end else if (cmd_hold_r == ccr_pkg::CMD_CHARGE_CURRENT) begin
				iset_nxt = data_hold_r;
				got_i_nxt = 1'b1;
				wd_nxt = 40'h0;
			end
		end else if (wd_expire) begin
			// Any word in the expiry cycle wins; a voltage or current write re-arms, any other word lets the counter run past expiry
			got_v_nxt = 1'b0;
			got_i_nxt = 1'b0;
			wd_nxt = 40'h0;
		end
		// Fields above bit 12 never reach the limit; sub-step requests round up to one step
		ilim_eff = {3'b000, ilim_r[ccr_pkg::INPUT_LIMIT_MSB:ccr_pkg::INPUT_LIMIT_LSB],
			7'h00};
		if (ilim_r[12:0] != 13'h0000 && ilim_r[12:7] == 6'h00) begin
			ilim_eff = 16'h0080;
		end
		adapter_nxt = in_ok & det;
		od_oe_nxt = ~det;
		en_nxt = adapter_r & got_v_r & got_i_r & ~wd_expire
			& (vset_r != 16'h0000) & (iset_r != 16'h0000)
			& ~pfail
			& in_ok & gd_ok & ref_ok & head_ok & bus_ok_s2_r;
	end

	// Settings live here as long as the bus supply holds; only undervoltage or reset clears them
	always_ff @(posedge i_clk or negedge rst_s2_n_r) begin
		if (!rst_s2_n_r) begin
			ilim_r <= ccr_pkg::INPUT_LIMIT_RESET;
			vset_r <= ccr_pkg::CHARGE_VOLTAGE_RESET;
			iset_r <= ccr_pkg::CHARGE_CURRENT_RESET;
			got_v_r <= 1'b0;
			got_i_r <= 1'b0;
			wd_r <= 40'h0;
			adapter_r <= 1'b0;
			en_r <= 1'b0;
			od_oe_r <= 1'b1;
			o_input_limit <= 16'h0000;
		end else begin
			ilim_r <= ilim_nxt;
			vset_r <= vset_nxt;
			iset_r <= iset_nxt;
			got_v_r <= got_v_nxt;
			got_i_r <= got_i_nxt;
			wd_r <= wd_nxt;
			adapter_r <= adapter_nxt;
			en_r <= en_nxt;
			od_oe_r <= od_oe_nxt;
			o_input_limit <= ilim_eff;
		end
	end

	assign o_charge_enable = en_r;
	assign o_charge_voltage = vset_r;
	assign o_charge_current = iset_r;
	assign o_adapter_present_output_out = 1'b0;
	assign o_adapter_present_output_oe = od_oe_r;
endmodule

// ---- src/ccr_smbus_rx.sv ----
// Receives SMBus write-word frames on the bus's own clock and hands each word over with a toggle.
module ccr_smbus_rx (
	input wire logic i_scl,
	input wire logic i_rst_n,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic [7:0] o_cmd,
	output logic [15:0] o_data,
	output logic o_word_tgl
);
	typedef enum logic [4:0] {
		CCR_RX_ADDR = 5'b00001,
		CCR_RX_CMD = 5'b00010,
		CCR_RX_LO = 5'b00100,
		CCR_RX_HI = 5'b01000,
		CCR_RX_IDLE = 5'b10000
	} ccr_rx_e;

	// Start is seen by an SDA fall while SCL is high; SCL stands still outside frames
	// A stop needs no tracking: the frame has already gone idle after the high byte
	logic start_r;
	always_ff @(negedge i_sda_in or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_r <= 1'b0;
		end else begin
			start_r <= i_scl ? ~start_r : start_r;
		end
	end

	ccr_rx_e state_r, state_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [7:0] lo_r, lo_nxt;
	logic [15:0] data_r, data_nxt;
	logic tgl_r, tgl_nxt;
	logic start_seen_r, start_seen_nxt;
	logic ack_r, ack_nxt;
	logic [7:0] sh_in;

	always_comb begin
		sh_in = {sh_r[6:0], i_sda_in};
		state_nxt = state_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		cmd_nxt = cmd_r;
		lo_nxt = lo_r;
		data_nxt = data_r;
		tgl_nxt = tgl_r;
		start_seen_nxt = start_r;
		ack_nxt = 1'b0;
		if (start_seen_r != start_r) begin
			// First rising edge after a start carries address bit 6
			state_nxt = CCR_RX_ADDR;
			bit_nxt = 4'h1;
			sh_nxt = {7'h00, i_sda_in};
		end else if (state_r != CCR_RX_IDLE) begin
			if (bit_r == 4'h8) begin
				bit_nxt = 4'h0;
				case (state_r)
					CCR_RX_ADDR: state_nxt = CCR_RX_CMD;
					CCR_RX_CMD: state_nxt = CCR_RX_LO;
					CCR_RX_LO: state_nxt = CCR_RX_HI;
					default: state_nxt = CCR_RX_IDLE;
				endcase
			end else begin
				bit_nxt = bit_r + 4'h1;
				sh_nxt = sh_in;
				if (bit_r == 4'h7) begin
					ack_nxt = 1'b1;
					case (state_r)
						CCR_RX_ADDR: begin
							if (sh_in != {ccr_pkg::SLAVE_ADDR, 1'b0}) begin
								state_nxt = CCR_RX_IDLE;
								ack_nxt = 1'b0;
							end
						end
						CCR_RX_CMD: cmd_nxt = sh_in;
						CCR_RX_LO: lo_nxt = sh_in;
						default: begin
							data_nxt = {sh_in, lo_r};
							tgl_nxt = ~tgl_r;
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= CCR_RX_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			cmd_r <= 8'h00;
			lo_r <= 8'h00;
			data_r <= 16'h0000;
			tgl_r <= 1'b0;
			start_seen_r <= 1'b0;
			ack_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			cmd_r <= cmd_nxt;
			lo_r <= lo_nxt;
			data_r <= data_nxt;
			tgl_r <= tgl_nxt;
			start_seen_r <= start_seen_nxt;
			ack_r <= ack_nxt;
		end
	end

	// Acknowledge is driven from the falling edge so SDA changes only while SCL is low
	logic drive_r;
	always_ff @(negedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			drive_r <= 1'b0;
		end else begin
			drive_r <= ack_r;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = drive_r;
	assign o_cmd = cmd_r;
	assign o_data = data_r;
	assign o_word_tgl = tgl_r;
endmodule

// ---- verification/ccr_charger_core_tb_top.sv ----
module ccr_charger_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] AD = ccr_pkg::SLAVE_ADDR;
	localparam logic [7:0] CV = ccr_pkg::CMD_CHARGE_VOLTAGE;
	localparam logic [7:0] CC = ccr_pkg::CMD_CHARGE_CURRENT;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic bus_ok = 1'b1;
	logic [5:0] flg = 6'h3F;
	logic scl, sda, host_low, sda_out, sda_oe, ad_out, ad_oe, en, ack;
	logic [15:0] lim, volt, curr;
	int fail_count = 0;
	int total_checks = 0;
	always #5 i_clk = !i_clk;
	assign sda = !(host_low | (sda_oe & !sda_out));
	ccr_host host (.o_scl(scl), .o_sda_low(host_low), .i_sda(sda));
	ccr_charger_core #(.WATCHDOG_CYCLES(1000)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda_in(sda),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_bus_supply_ok(bus_ok), .i_input_supply_ok(flg[5]),
		.i_gate_drive_supply_ok(flg[4]), .i_reference_ok(flg[3]), .i_headroom_ok(flg[2]), .i_power_fail(!flg[1]),
		.i_adapter_detect_input(flg[0]), .o_adapter_present_output_out(ad_out), .o_adapter_present_output_oe(ad_oe),
		.o_charge_enable(en), .o_input_limit(lim), .o_charge_voltage(volt), .o_charge_current(curr));
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d);
		host.write_word(a, c, d, ack);
		repeat (5) @(negedge i_clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic t_reset();
		chk({en, volt}, 17'h00000);
		chk({1'b0, curr}, {1'b0, ccr_pkg::CHARGE_CURRENT_RESET});
		chk({1'b0, lim}, {1'b0, ccr_pkg::INPUT_LIMIT_RESET});
		chk({15'h0000, ad_out, ad_oe}, 17'h00000);
		flg[0] = 1'b0;
		repeat (4) @(negedge i_clk);
		chk({15'h0000, ad_out, ad_oe}, 17'h00001);
		flg[0] = 1'b1;
		repeat (4) @(negedge i_clk);
	endtask
	task automatic t_limit();
		logic [15:0] req [5] = '{16'h0001, 16'h007F, 16'hE480, 16'h1580, 16'h0800};
		logic [15:0] exp [5] = '{16'h0080, 16'h0080, 16'h0480, 16'h1580, 16'h0800};
		for (int i = 0; i < 5; i++) begin
			wr(AD, ccr_pkg::CMD_INPUT_LIMIT, req[i]);
			chk({1'b0, lim}, {1'b0, exp[i]});
		end
		wr(7'h0A, ccr_pkg::CMD_INPUT_LIMIT, 16'h0100);
		chk({16'h0000, ack}, 17'h00000);
		wr(AD, 8'h16, 16'h0100);
		chk({ack, lim}, 17'h10800);
	endtask
	task automatic t_enable();
		wr(AD, CV, 16'h3000);
		chk({en, volt}, 17'h03000);
		wr(AD, CC, 16'h0400);
		chk({en, curr}, 17'h10400);
		for (int i = 0; i < 6; i++) begin
			flg[i] = 1'b0;
			repeat (5) @(negedge i_clk);
			chk({16'h0000, en}, 17'h00000);
			flg[i] = 1'b1;
			repeat (5) @(negedge i_clk);
			chk({16'h0000, en}, 17'h00001);
		end
	endtask
	task automatic t_zero();
		for (int i = 0; i < 2; i++) begin
			wr(AD, i ? CV : CC, 16'h0000);
			chk({16'h0000, en}, 17'h00000);
			wr(AD, i ? CV : CC, 16'h0880);
			chk({16'h0000, en}, 17'h00001);
		end
	endtask
	task automatic t_wdog();
		repeat (600) @(negedge i_clk);
		wr(AD, CV, 16'h3000);
		repeat (600) @(negedge i_clk);
		chk({16'h0000, en}, 17'h00001);
		repeat (500) @(negedge i_clk);
		chk({16'h0000, en}, 17'h00000);
		wr(AD, CV, 16'h3010);
		chk({16'h0000, en}, 17'h00000);
		wr(AD, CC, 16'h0400);
		chk({16'h0000, en}, 17'h00001);
	endtask
	task automatic t_uv();
		bus_ok = 1'b0;
		repeat (2) @(negedge i_clk);
		chk({en, volt | curr | lim}, 17'h00000);
		wr(AD, ccr_pkg::CMD_INPUT_LIMIT, 16'h0100);
		chk({ack, lim}, 17'h00000);
		bus_ok = 1'b1;
		repeat (5) @(negedge i_clk);
		wr(AD, CV, 16'h3000);
		chk({16'h0000, en}, 17'h00000);
		wr(AD, CC, 16'h0400);
		chk({16'h0000, en}, 17'h00001);
	endtask
	initial begin
		repeat (3) @(negedge i_clk);
		i_rst_n = 1'b1;
		repeat (4) @(negedge i_clk);
		t_reset();
		t_limit();
		t_enable();
		t_zero();
		t_wdog();
		t_uv();
		stop_test();
	end
	initial begin
		#300000;
		fail_count++;
		stop_test();
	end
endmodule

// ---- verification/ccr_chk.sv ----
module ccr_chk #(
	parameter longint WATCHDOG_CYCLES = 1000
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda_in,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic i_bus_supply_ok,
	input wire logic i_input_supply_ok,
	input wire logic i_gate_drive_supply_ok,
	input wire logic i_reference_ok,
	input wire logic i_headroom_ok,
	input wire logic i_power_fail,
	input wire logic i_adapter_detect_input,
	input wire logic o_adapter_present_output_out,
	input wire logic o_adapter_present_output_oe,
	input wire logic o_charge_enable,
	input wire logic [15:0] o_input_limit,
	input wire logic [15:0] o_charge_voltage,
	input wire logic [15:0] o_charge_current
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] volt_r;
	logic [15:0] curr_r;
	longint cnt_r;
	longint cnt_nxt;
	logic bad;
	// A refresh with an unchanged value is invisible here, so refreshes must change the word
	assign bad = i_power_fail | !i_input_supply_ok | !i_gate_drive_supply_ok | !i_reference_ok | !i_headroom_ok;
	always_comb begin
		cnt_nxt = cnt_r;
		if (volt_r != o_charge_voltage || curr_r != o_charge_current) begin
			cnt_nxt = 0;
		end else if (o_charge_enable) begin
			cnt_nxt = cnt_r + 1;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 0;
			volt_r <= 16'h0000;
			curr_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_nxt;
			volt_r <= o_charge_voltage;
			curr_r <= o_charge_current;
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	AST_ADAPTER_REL: assert property (
		(i_adapter_detect_input && i_bus_supply_ok) [*4] |-> !o_adapter_present_output_oe)
		else $error("adapter output not released");
	AST_ADAPTER_LOW: assert property (
		!i_adapter_detect_input [*4] |-> o_adapter_present_output_oe && !o_adapter_present_output_out)
		else $error("adapter output not driven low");
	AST_QUAL: assert property ((bad || !i_adapter_detect_input) [*5] |-> !o_charge_enable)
		else $error("charging without qualifying flags");
	AST_ZERO: assert property (
		o_charge_enable |-> $past(o_charge_voltage) != 16'h0000 && $past(o_charge_current) != 16'h0000)
		else $error("charging with a zero setting");
	AST_LIMIT: assert property (o_input_limit[15:13] == 3'h0 && o_input_limit[6:0] == 7'h00)
		else $error("limit word outside its field");
	AST_RESET: assert property (
		$rose(i_rst_n) |-> o_charge_voltage == 16'h0000 && o_charge_current == 16'h0000 && !o_charge_enable)
		else $error("settings not cleared by reset");
	AST_BUS_UV: assert property (
		!i_bus_supply_ok |-> o_charge_voltage == 16'h0000 && o_input_limit == 16'h0000 && !o_sda_oe)
		else $error("registers live during undervoltage");
	AST_UV_EXIT: assert property ($rose(i_bus_supply_ok) |-> !o_charge_enable [*8])
		else $error("charging right after undervoltage");
	AST_WDOG: assert property (cnt_r <= WATCHDOG_CYCLES + 4)
		else $error("watchdog did not stop charging");
	AST_ACK_SCL: assert property ($rose(o_sda_oe) |-> !i_scl && !o_sda_out)
		else $error("data line pulled while clock high");
endmodule

bind ccr_charger_core ccr_chk #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_bus_supply_ok(i_bus_supply_ok),
	.i_input_supply_ok(i_input_supply_ok), .i_gate_drive_supply_ok(i_gate_drive_supply_ok),
	.i_reference_ok(i_reference_ok), .i_headroom_ok(i_headroom_ok), .i_power_fail(i_power_fail),
	.i_adapter_detect_input(i_adapter_detect_input), .o_adapter_present_output_out(o_adapter_present_output_out),
	.o_adapter_present_output_oe(o_adapter_present_output_oe), .o_charge_enable(o_charge_enable),
	.o_input_limit(o_input_limit), .o_charge_voltage(o_charge_voltage), .o_charge_current(o_charge_current));

// ---- verification/ccr_host.sv ----
module ccr_host (
	output logic o_scl,
	output logic o_sda_low,
	input wire logic i_sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic got_ack;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// Clock stands high between frames; inside a byte data moves only while it is low
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			o_sda_low = !b[i];
			#24 o_scl = 1'b1;
			#24 o_scl = 1'b0;
		end
		o_sda_low = 1'b0;
		#24 o_scl = 1'b1;
		got_ack = (i_sda === 1'b0);
		#24 o_scl = 1'b0;
	endtask
	task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, output logic ack);
		#3 o_sda_low = 1'b1;
		#24 o_scl = 1'b0;
		send_byte({a, 1'b0});
		ack = got_ack;
		if (ack) begin
			send_byte(c);
			send_byte(d[7:0]);
			send_byte(d[15:8]);
		end
		o_sda_low = 1'b1;
		#24 o_scl = 1'b1;
		#24 o_sda_low = 1'b0;
		#24;
	endtask
endmodule
